// file: src/samon_top.sv
// Scan sequencer, scaling, limit checking and alarm queue.
// Assumes the front end returns one reading per requested channel.
//
// Contract
// - Four alarms, any channels per alarm
// - High, low or both limit modes
// - Limits default to zero
// - Low limit never above high limit
// - Config change clears alarms and limits
// - Factory reset clears limits; preset keeps
// - Alarm status stored with reading
// - New scan clears reading memory
// - Alarm queue separate, twenty entries
// - Reading queue removes read alarms
// - Interval start to start, 0-99 hours
// - Count 1..50000 or continuous, then stop
// - Sweep from timer or external trigger
// - Scaling applies gain and offset
// - Factory reset clears scaling; preset keeps
// - Monitor one channel, even during scan
// - Optional label defaults to function unit
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "samon_params.svh"
module samon_top
#(
   parameter int NCH       = 20,
   parameter int TICK_CYC  = `SAMON_TICK_CYC,
   parameter int QDEPTH    = `SAMON_QUEUE_DEPTH
)
(
   input  wire logic        core_clk_in,     // 250 MHz clock
   input  wire logic        nrst_in,         // Async reset, low
   input  wire logic [7:0]  addr_in,         // Register address
   input  wire logic [31:0] wdata_in,        // Write data
   input  wire logic        wr_in,           // Write strobe
   input  wire logic        rd_in,           // Read strobe
   output logic      [31:0] rdata_out,       // Read data, next cycle
   input  wire logic        ext_trig_in,     // TTL trigger pin
   input  wire samon_pkg::samon_rdg_s rdg_in, // Front end reading
   output logic             meas_req_out,    // Request a reading
   output logic      [4:0]  meas_chan_out,   // Channel to measure
   output logic      [3:0]  alarm_out,       // Alarm lines 1..4
   output logic             irq_out          // Level interrupt
);
   localparam int CW = 5;
   // Signed fixed-point gain (16.16) product to 32 bits
   function automatic logic [31:0] scale_f(input logic [31:0] v,
      input logic [31:0] m, input logic [31:0] b);
      logic signed [63:0] p;
      p = $signed(v) * $signed(m);
      return 32'(p >>> 16) + b;
   endfunction
   // Signed less-than used by limit checks
   function automatic logic lt_f(input logic [31:0] a,
      input logic [31:0] b);
      return $signed(a) < $signed(b);
   endfunction

   // Per-channel storage
   samon_pkg::samon_cfg_s cfg_ff [NCH];   // Setup
   logic [31:0] hi_ff  [NCH];             // High limit
   logic [31:0] lo_ff  [NCH];             // Low limit
   logic [31:0] gain_ff[NCH];             // Gain
   logic [31:0] offs_ff[NCH];             // Offset
   logic [31:0] mem_ff [NCH];             // Reading memory
   logic [1:0]  malm_ff[NCH];             // Stored alarm status
   logic [NCH-1:0] mvld_ff;               // Reading present
   // Alarm queue
   samon_pkg::samon_alm_s q_ff[QDEPTH];
   logic [4:0]  qwp_ff, qrp_ff;           // Pointers
   logic [5:0]  qcnt_ff;                  // Fill level
   // Registers
   logic [CW-1:0] sel_ff;                 // Channel being edited
   logic [CW-1:0] mon_ff;                 // Monitored channel
   logic          mon_en_ff;              // Monitor on
   logic [31:0]   mon_data_ff;            // Last monitor reading
   logic [CW-1:0] midx_ff;                // Memory read index
   logic          ext_mode_ff;            // Trigger source
   logic [31:0]   ival_ff;                // Interval in ms
   logic [15:0]   scnt_ff;                // Count, 0 = continuous
   logic [3:0]    irq_st_ff, irq_mk_ff;   // Interrupt status, mask
   // Sequencer
   samon_pkg::samon_scan_e st_ff;
   logic [31:0]   tick_ff, ms_ff;         // Interval timer
   logic [15:0]   done_ff;                // Sweeps done
   logic [CW-1:0] sch_ff;                 // Sweep channel
   logic          pend_ff;                // Reading outstanding
   logic          mon_turn_ff;            // Last request was for monitor
   logic          trig_s1_ff, trig_s2_ff, trig_s3_ff;
   // Decodes
   logic wr_ctrl, start_cmd, stop_cmd, factory, sweep_go, sweep_end;
   logic trig_rise, rdg_scan, rdg_mon, qpop, qpush;
   logic [31:0] scaled, cur_lo, cur_hi;
   logic [CW-1:0] rch;
   logic alm_hi, alm_lo, alm_any;
   samon_pkg::samon_cfg_s rcfg;

   assign wr_ctrl   = wr_in && addr_in == `SAMON_REG_CTRL;
   assign start_cmd = wr_ctrl && wdata_in[`SAMON_CTRL_START];
   assign stop_cmd  = wr_ctrl && wdata_in[`SAMON_CTRL_STOP];
   assign factory   = wr_ctrl && wdata_in[`SAMON_CTRL_FACTORY];
   // Preset bit deliberately touches neither limits nor scaling
   assign rch   = rdg_in.chan;
   assign rcfg  = cfg_ff[rch];
   assign rdg_scan = rdg_in.valid && pend_ff && !mon_turn_ff;
   assign rdg_mon  = rdg_in.valid && pend_ff && mon_turn_ff;
   // Scaled value when enabled
   assign scaled = rcfg.scale_en ?
      scale_f(rdg_in.value, gain_ff[rch], offs_ff[rch]) : rdg_in.value;
   assign cur_hi = hi_ff[rch];
   assign cur_lo = lo_ff[rch];
   // Compare scaled reading against active limits
   assign alm_hi = (rcfg.mode == samon_pkg::LIM_HI ||
                    rcfg.mode == samon_pkg::LIM_BOTH) &&
                   lt_f(cur_hi, scaled);
   assign alm_lo = (rcfg.mode == samon_pkg::LIM_LO ||
                    rcfg.mode == samon_pkg::LIM_BOTH) &&
                   lt_f(scaled, cur_lo);
   assign alm_any = rdg_scan && (alm_hi || alm_lo);
   assign trig_rise = trig_s2_ff && !trig_s3_ff;
   // Sweep from timer or external edge
   assign sweep_go = st_ff == samon_pkg::SCN_WAIT &&
      (ext_mode_ff ? trig_rise : ms_ff >= ival_ff);
   assign sweep_end = rdg_scan && sch_ff == CW'(NCH - 1);
   assign qpop  = rd_in && addr_in == `SAMON_REG_QUEUE && qcnt_ff != 0;
   assign qpush = alm_any && (qcnt_ff != 6'(QDEPTH) || qpop);

   // Trigger pin synchroniser plus edge stage
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         trig_s1_ff <= 1'b0;
         trig_s2_ff <= 1'b0;
         trig_s3_ff <= 1'b0;
      end
      else
      begin
         trig_s1_ff <= ext_trig_in;
         trig_s2_ff <= trig_s1_ff;
         trig_s3_ff <= trig_s2_ff;
      end
   end

   // Channel setup, limits and scaling
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         for (int i = 0; i < NCH; i++)
         begin
            cfg_ff[i]  <= '0;
            hi_ff[i]   <= `SAMON_LIM_RST;
            lo_ff[i]   <= `SAMON_LIM_RST;
            gain_ff[i] <= `SAMON_GAIN_ONE;
            offs_ff[i] <= `SAMON_OFFS_RST;
         end
      end
      else if (factory)
      begin
         // Factory reset clears mode, scaling, label, limits, gain and offset; function and alarm number kept
         for (int i = 0; i < NCH; i++)
         begin
            cfg_ff[i].mode     <= samon_pkg::LIM_OFF;
            cfg_ff[i].scale_en <= 1'b0;
            cfg_ff[i].label    <= '0;
            hi_ff[i]   <= `SAMON_LIM_RST;
            lo_ff[i]   <= `SAMON_LIM_RST;
            gain_ff[i] <= `SAMON_GAIN_ONE;
            offs_ff[i] <= `SAMON_OFFS_RST;
         end
      end
      else if (wr_in)
      begin
         case (addr_in)
            `SAMON_REG_CH_CFG:
            begin
               // Function change drops alarms and scaling
               if (wdata_in[`SAMON_CFG_FUNC_LSB +: 4] != cfg_ff[sel_ff].func)
               begin
                  cfg_ff[sel_ff].func     <= wdata_in[3:0];
                  cfg_ff[sel_ff].mode     <= samon_pkg::LIM_OFF;
                  cfg_ff[sel_ff].scale_en <= 1'b0;
                  hi_ff[sel_ff]   <= `SAMON_LIM_RST;
                  lo_ff[sel_ff]   <= `SAMON_LIM_RST;
                  gain_ff[sel_ff] <= `SAMON_GAIN_ONE;
                  offs_ff[sel_ff] <= `SAMON_OFFS_RST;
               end
               else
               begin
                  // Any alarm number per channel
                  cfg_ff[sel_ff].mode <= samon_pkg::samon_lim_e'(
                     wdata_in[`SAMON_CFG_MODE_LSB +: 2]);
                  cfg_ff[sel_ff].alarm_no <=
                     wdata_in[`SAMON_CFG_ALM_LSB +: 2];
                  cfg_ff[sel_ff].scale_en <= wdata_in[`SAMON_CFG_SCALE];
               end
            end
            // Limit writes refused if they would invert the pair
            `SAMON_REG_HI_LIM:
               if (!lt_f(wdata_in, lo_ff[sel_ff]))
                  hi_ff[sel_ff] <= wdata_in;
            `SAMON_REG_LO_LIM:
               if (!lt_f(hi_ff[sel_ff], wdata_in))
                  lo_ff[sel_ff] <= wdata_in;
            `SAMON_REG_GAIN:  gain_ff[sel_ff] <= wdata_in;
            `SAMON_REG_OFFS:  offs_ff[sel_ff] <= wdata_in;
            // Zero label means function's standard unit
            `SAMON_REG_LABEL: cfg_ff[sel_ff].label <= wdata_in[23:0];
            default: ;
         endcase
      end
   end

   // Plain control registers
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         sel_ff      <= '0;
         mon_ff      <= '0;
         mon_en_ff   <= 1'b0;
         midx_ff     <= '0;
         ext_mode_ff <= 1'b0;
         ival_ff     <= '0;
         scnt_ff     <= '0;
         irq_mk_ff   <= '0;
      end
      else if (wr_in)
      begin
         case (addr_in)
            `SAMON_REG_CTRL:     ext_mode_ff <= wdata_in[`SAMON_CTRL_EXT];
            `SAMON_REG_CH_SEL:   sel_ff  <= wdata_in[CW-1:0];
            // Reselect monitor channel any time
            `SAMON_REG_MON_SEL:
            begin
               mon_ff    <= wdata_in[CW-1:0];
               mon_en_ff <= wdata_in[31];
            end
            `SAMON_REG_MEM_IDX:  midx_ff <= wdata_in[CW-1:0];
            // Clamp to 99 hours
            `SAMON_REG_INTERVAL:
               ival_ff <= (wdata_in > `SAMON_MAX_INTERVAL) ?
                          32'(`SAMON_MAX_INTERVAL) : wdata_in;
            // Clamp count to 50000; zero is continuous
            `SAMON_REG_COUNT:
               scnt_ff <= (wdata_in > `SAMON_MAX_COUNT) ?
                          16'(`SAMON_MAX_COUNT) : wdata_in[15:0];
            `SAMON_REG_IRQ_MASK: irq_mk_ff <= wdata_in[3:0];
            default: ;
         endcase
      end
   end

   // Scan sequencer and interval timer
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         st_ff   <= samon_pkg::SCN_IDLE;
         tick_ff <= '0;
         ms_ff   <= '0;
         done_ff <= '0;
         sch_ff  <= '0;
      end
      else if (stop_cmd)
         st_ff <= samon_pkg::SCN_IDLE;
      else
      begin
         // Millisecond tick runs from each sweep start
         if (tick_ff == 32'(TICK_CYC - 1) || sweep_go)
         begin
            tick_ff <= '0;
            ms_ff   <= sweep_go ? 32'd0 : ms_ff + 32'd1;
         end
         else
            tick_ff <= tick_ff + 32'd1;
         case (st_ff)
            samon_pkg::SCN_IDLE:
               if (start_cmd)
               begin
                  st_ff   <= samon_pkg::SCN_WAIT;
                  done_ff <= '0;
                  ms_ff   <= ival_ff;   // First sweep at once
               end
            samon_pkg::SCN_WAIT:
               if (sweep_go)
               begin
                  st_ff  <= samon_pkg::SCN_SWEEP;
                  sch_ff <= '0;
               end
            samon_pkg::SCN_SWEEP:
               if (sweep_end)
               begin
                  done_ff <= done_ff + 16'd1;
                  // Stop after programmed count
                  st_ff <= (scnt_ff != 0 && done_ff + 16'd1 >= scnt_ff) ?
                           samon_pkg::SCN_IDLE : samon_pkg::SCN_WAIT;
               end
               else if (rdg_scan)
                  sch_ff <= sch_ff + CW'(1);
            default: st_ff <= samon_pkg::SCN_IDLE;
         endcase
      end
   end

   // Measurement requests, monitor interleaved with scan
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         meas_req_out  <= 1'b0;
         meas_chan_out <= '0;
         pend_ff       <= 1'b0;
         mon_turn_ff   <= 1'b0;
         mon_data_ff   <= '0;
      end
      else
      begin
         meas_req_out <= 1'b0;
         if (rdg_in.valid)
            pend_ff <= 1'b0;
         if (rdg_mon)
            mon_data_ff <= rdg_in.value;
         if (!pend_ff && !meas_req_out)
         begin
            // Alternate slots so monitor runs during scans
            if (mon_en_ff &&
                (!mon_turn_ff || st_ff != samon_pkg::SCN_SWEEP))
            begin
               meas_req_out  <= 1'b1;
               meas_chan_out <= mon_ff;
               mon_turn_ff   <= 1'b1;
               pend_ff       <= 1'b1;
            end
            else if (st_ff == samon_pkg::SCN_SWEEP && !sweep_end)
            begin
               meas_req_out  <= 1'b1;
               meas_chan_out <= sch_ff;
               mon_turn_ff   <= 1'b0;
               pend_ff       <= 1'b1;
            end
         end
      end
   end

   // Reading memory with alarm status
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         mvld_ff <= '0;
         for (int i = 0; i < NCH; i++)
         begin
            mem_ff[i]  <= '0;
            malm_ff[i] <= '0;
         end
      end
      else if (start_cmd && st_ff == samon_pkg::SCN_IDLE)
         mvld_ff <= '0;
      else if (rdg_scan)
      begin
         mem_ff[rch]  <= scaled;
         malm_ff[rch] <= {alm_hi, alm_lo};
         mvld_ff[rch] <= 1'b1;
      end
   end

   // Alarm queue, oldest first, twenty deep
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         qwp_ff  <= '0;
         qrp_ff  <= '0;
         qcnt_ff <= '0;
         for (int i = 0; i < QDEPTH; i++)
            q_ff[i] <= '0;
      end
      else
      begin
         if (qpush)
         begin
            q_ff[qwp_ff] <= '{rch, rcfg.alarm_no, alm_hi, scaled[23:0]};
            qwp_ff <= (qwp_ff == 5'(QDEPTH - 1)) ? 5'd0 : qwp_ff + 5'd1;
         end
         if (qpop)
            qrp_ff <= (qrp_ff == 5'(QDEPTH - 1)) ? 5'd0 : qrp_ff + 5'd1;
         qcnt_ff <= qcnt_ff + 6'(qpush) - 6'(qpop);
      end
   end

   // Alarm lines, interrupt status and interrupt output
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         alarm_out <= '0;
         irq_st_ff <= '0;
         irq_out   <= 1'b0;
      end
      else
      begin
         if (alm_any)
            alarm_out[rcfg.alarm_no] <= 1'b1;
         else if (start_cmd)
            alarm_out <= '0;
         // Write one clears, new event wins
         irq_st_ff <= (irq_st_ff & ~((wr_in &&
                       addr_in == `SAMON_REG_IRQ_STAT) ? wdata_in[3:0]
                       : 4'h0)) |
                      {alm_any && !qpush,
                       sweep_end && st_ff == samon_pkg::SCN_SWEEP &&
                       scnt_ff != 0 && done_ff + 16'd1 >= scnt_ff,
                       sweep_end, alm_any};
         irq_out <= |(irq_st_ff & irq_mk_ff);
      end
   end

   // Read data, one cycle after the strobe
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         rdata_out <= '0;
      else if (rd_in)
      begin
         case (addr_in)
            `SAMON_REG_CTRL:     rdata_out <= {29'h0, ext_mode_ff, 2'b00};
            `SAMON_REG_STAT:     rdata_out <= {8'h0, done_ff,
                                  qcnt_ff, 2'(st_ff)};
            `SAMON_REG_IRQ_STAT: rdata_out <= {28'h0, irq_st_ff};
            `SAMON_REG_IRQ_MASK: rdata_out <= {28'h0, irq_mk_ff};
            `SAMON_REG_CH_SEL:   rdata_out <= {27'h0, sel_ff};
            `SAMON_REG_CH_CFG:   rdata_out <= {23'h0, cfg_ff[sel_ff].scale_en,
               cfg_ff[sel_ff].alarm_no, 2'(cfg_ff[sel_ff].mode),
               cfg_ff[sel_ff].func};
            `SAMON_REG_HI_LIM:   rdata_out <= hi_ff[sel_ff];
            `SAMON_REG_LO_LIM:   rdata_out <= lo_ff[sel_ff];
            `SAMON_REG_GAIN:     rdata_out <= gain_ff[sel_ff];
            `SAMON_REG_OFFS:     rdata_out <= offs_ff[sel_ff];
            `SAMON_REG_LABEL:    rdata_out <= {8'h0, cfg_ff[sel_ff].label};
            `SAMON_REG_INTERVAL: rdata_out <= ival_ff;
            `SAMON_REG_COUNT:    rdata_out <= {16'h0, scnt_ff};
            `SAMON_REG_QUEUE:    rdata_out <= (qcnt_ff != 0) ?
                                  q_ff[qrp_ff] : 32'h0;
            `SAMON_REG_MON_SEL:  rdata_out <= {mon_en_ff, 26'h0, mon_ff};
            `SAMON_REG_MON_DATA: rdata_out <= mon_data_ff;
            `SAMON_REG_MEM_IDX:  rdata_out <= {27'h0, midx_ff};
            `SAMON_REG_MEM_DATA: rdata_out <= mvld_ff[midx_ff] ?
                                  mem_ff[midx_ff] : 32'h0;
            `SAMON_REG_MEM_ALM:  rdata_out <= {29'h0, mvld_ff[midx_ff],
                                  mvld_ff[midx_ff] ? malm_ff[midx_ff]
                                  : 2'b00};
            default:             rdata_out <= 32'h0;
         endcase
      end
   end
endmodule

// file: pkg/samon_params.svh
// Constants for the scan and alarm limit monitor: offsets, fields, resets,
// timing counts. Assumes a 250 MHz core clock and a 32-bit register port.
`ifndef SAMON_PARAMS_SVH
`define SAMON_PARAMS_SVH
// Register offsets (byte addresses)
`define SAMON_REG_CTRL      8'h00
`define SAMON_REG_STAT      8'h04
`define SAMON_REG_IRQ_STAT  8'h08
`define SAMON_REG_IRQ_MASK  8'h0C
`define SAMON_REG_CH_SEL    8'h10
`define SAMON_REG_CH_CFG    8'h14
`define SAMON_REG_HI_LIM    8'h18
`define SAMON_REG_LO_LIM    8'h1C
`define SAMON_REG_GAIN      8'h20
`define SAMON_REG_OFFS      8'h24
`define SAMON_REG_LABEL     8'h28
`define SAMON_REG_INTERVAL  8'h2C
`define SAMON_REG_COUNT     8'h30
`define SAMON_REG_QUEUE     8'h34
`define SAMON_REG_MON_SEL   8'h38
`define SAMON_REG_MON_DATA  8'h3C
`define SAMON_REG_MEM_IDX   8'h40
`define SAMON_REG_MEM_DATA  8'h44
`define SAMON_REG_MEM_ALM   8'h48
// Control bits (write-one actions and mode)
`define SAMON_CTRL_START    0
`define SAMON_CTRL_STOP     1
`define SAMON_CTRL_EXT      2
`define SAMON_CTRL_FACTORY  3
`define SAMON_CTRL_PRESET   4
// Channel config fields
`define SAMON_CFG_FUNC_LSB  0
`define SAMON_CFG_MODE_LSB  4
`define SAMON_CFG_ALM_LSB   6
`define SAMON_CFG_SCALE     8
// Interrupt bits
`define SAMON_IRQ_ALARM     0
`define SAMON_IRQ_SWEEP     1
`define SAMON_IRQ_DONE      2
`define SAMON_IRQ_QFULL     3
// Reset values
`define SAMON_GAIN_ONE      32'h0001_0000
`define SAMON_LIM_RST       32'h0000_0000
`define SAMON_OFFS_RST      32'h0000_0000
// Timing: interval unit of one millisecond at 250 MHz
`define SAMON_CLK_MHZ       250
`define SAMON_TICK_US       1000
`define SAMON_TICK_CYC      (`SAMON_TICK_US * `SAMON_CLK_MHZ)
// Interval ceiling: 99 hours expressed in milliseconds
`define SAMON_MAX_HOURS     99
`define SAMON_MAX_INTERVAL  (`SAMON_MAX_HOURS * 3600 * 1000)
`define SAMON_MAX_COUNT     50000
`define SAMON_QUEUE_DEPTH   20
`endif

// file: pkg/samon_pkg.sv
// Types for the scan and alarm limit monitor.
// Assumes samon_params.svh supplies every number.
package samon_pkg;
   // Limit mode of one channel
   typedef enum logic [1:0] {
      LIM_OFF,
      LIM_HI,
      LIM_LO,
      LIM_BOTH
   } samon_lim_e;
   // Scan sequencer states
   typedef enum logic [1:0] {
      SCN_IDLE,
      SCN_WAIT,
      SCN_SWEEP
   } samon_scan_e;
   // Per-channel setup
   typedef struct packed {
      logic [3:0]  func;
      samon_lim_e  mode;
      logic [1:0]  alarm_no;
      logic        scale_en;
      logic [23:0] label;
   } samon_cfg_s;
   // Reading from the front end
   typedef struct packed {
      logic        valid;
      logic [4:0]  chan;
      logic [31:0] value;
   } samon_rdg_s;
   // One alarm queue entry
   typedef struct packed {
      logic [4:0]  chan;
      logic [1:0]  alarm_no;
      logic        hi_side;
      logic [23:0] value;
   } samon_alm_s;
endpackage

// file: tb/samon_properties.sv
// Port checker for the scan and alarm monitor.
// Bound into samon_top; sees its ports only.
`timescale 1ns/1ps
module samon_chk
(
   input wire logic                  core_clk_in,
   input wire logic                  nrst_in,
   input wire logic [7:0]            addr_in,
   input wire logic [31:0]           wdata_in,
   input wire logic                  wr_in,
   input wire logic                  rd_in,
   input wire logic [31:0]           rdata_out,
   input wire samon_pkg::samon_rdg_s rdg_in,
   input wire logic                  meas_req_out,
   input wire logic [4:0]            meas_chan_out,
   input wire logic [3:0]            alarm_out,
   input wire logic                  irq_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);
   logic       busy_ff; // Reading outstanding
   logic [3:0] mask_ff; // Shadow of the mask
   logic [1:0] wcnt_ff; // Recent control or channel config write
   // Track link, mask and clearing writes
   always_ff @(posedge core_clk_in or negedge nrst_in)
      if (!nrst_in)
      begin
         busy_ff <= 1'b0;
         mask_ff <= 4'h0;
         wcnt_ff <= 2'h0;
      end
      else
      begin
         busy_ff <= meas_req_out | (busy_ff & ~rdg_in.valid);
         if (wr_in && addr_in == 8'h0C)
            mask_ff <= wdata_in[3:0];
         if (wr_in && (addr_in == 8'h00 || addr_in == 8'h14))
            wcnt_ff <= 2'h3;
         else if (wcnt_ff != 2'h0)
            wcnt_ff <= wcnt_ff - 2'h1;
      end
   req_pulse_a: assert property (meas_req_out |=> !meas_req_out)
      else $error("request wider than one cycle");
   chan_hold_a: assert property (!meas_req_out |->
      $stable(meas_chan_out))
      else $error("channel moved without request");
   one_out_a: assert property (meas_req_out |-> !busy_ff)
      else $error("second request outstanding");
   req_gap_a: assert property (rdg_in.valid |=> !meas_req_out)
      else $error("request too soon after reading");
   rdata_hold_a: assert property (!rd_in |=> $stable(rdata_out))
      else $error("read data moved without read");
   mask_read_a: assert property (rd_in && addr_in == 8'h0C |=>
      rdata_out[3:0] == mask_ff)
      else $error("mask readback wrong");
   irq_off_a: assert property (wr_in && addr_in == 8'h0C && wdata_in == '0
      ##1 !(wr_in && addr_in == 8'h0C) |=> !irq_out)
      else $error("interrupt high with mask clear");
   alarm_hold_a: assert property (|($past(alarm_out) & ~alarm_out)
      |-> wcnt_ff != 2'h0)
      else $error("alarm line dropped by itself");
endmodule
bind samon_top samon_chk samon_chk_inst (.core_clk_in(core_clk_in),
   .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
   .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .rdg_in(rdg_in),
   .meas_req_out(meas_req_out), .meas_chan_out(meas_chan_out),
   .alarm_out(alarm_out), .irq_out(irq_out));

// file: tb/samon_front.sv
// Front end model: one reading per request, value is channel times 256.
// Assumes one request outstanding; slow_in stretches the answer.
`timescale 1ns/1ps
module samon_front
(
   input  wire logic             core_clk_in,
   input  wire logic             meas_req_out,
   input  wire logic [4:0]       meas_chan_out,
   input  wire logic             slow_in,
   output samon_pkg::samon_rdg_s rdg_out
);
   // Answer requests; value toggles when idle so stale data shows
   initial
   begin
      rdg_out = '0;
      forever
      begin
         @(posedge core_clk_in);
         rdg_out <= {1'b0, 5'h0, ~rdg_out.value};
         if (meas_req_out)
         begin
            repeat (slow_in ? 6 : 1) @(posedge core_clk_in);
            rdg_out <= {1'b1, meas_chan_out, 19'h0, meas_chan_out, 8'h00};
         end
      end
   end
endmodule

// file: tb/testbench.sv
// Bench for samon_top with the front end model.
// Assumes the designer's register map and a short timer tick.
`timescale 1ns/1ps
module testbench;
   logic clk, nrst, wr, rd, trig, slow, req, irq;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, v;
   logic [4:0]  chan;
   logic [3:0]  alarm;
   samon_pkg::samon_rdg_s rdg;
   int error_cnt, checks;
   samon_top #(.TICK_CYC(4)) samon_top_inst (.core_clk_in(clk),
      .nrst_in(nrst), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
      .rd_in(rd), .rdata_out(rdata), .ext_trig_in(trig), .rdg_in(rdg),
      .meas_req_out(req), .meas_chan_out(chan), .alarm_out(alarm),
      .irq_out(irq));
   samon_front samon_front_inst (.core_clk_in(clk), .meas_req_out(req),
      .meas_chan_out(chan), .slow_in(slow), .rdg_out(rdg));
   // 250 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: %h vs %h", $time, seen, exp);
      end
   endtask
   task automatic wrr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      rdr(a);
      chk(v, e);
   endtask
   // Select channel, set function then full setup, then limits
   task automatic chan_set(input logic [4:0] c, input logic [31:0] cfg,
                           input logic [31:0] hi, input logic [31:0] lo);
      wrr(8'h10, {27'h0, c});
      wrr(8'h14, 32'h0000_0001);
      wrr(8'h14, cfg);
      wrr(8'h18, hi);
      wrr(8'h1C, lo);
   endtask
   // One sweep; external mode waits for the trigger pin
   task automatic scan(input logic [31:0] c);
      wrr(8'h30, 32'h0000_0001);
      wrr(8'h08, 32'h0000_000F);
      wrr(8'h00, c);
      if (c[2])
      begin
         repeat (20) @(posedge clk);
         rdr(8'h08);
         chk(v[2], 1'b0);
         trig <= 1'b1;
         repeat (3) @(posedge clk);
         trig <= 1'b0;
      end
      v = '0;
      for (int i = 0; i < 300 && !v[2]; i++)
         rdr(8'h08);
      chk(v[2], 1'b1);
   endtask
   task automatic t_regs;
      rchk(8'h18, 32'h0000_0000);
      rchk(8'h1C, 32'h0000_0000);
      rchk(8'h20, 32'h0001_0000);
      chan_set(6, 32'h0000_0031, 32'h0000_0100, 32'h0000_0000);
      wrr(8'h14, 32'h0000_0032);
      rchk(8'h18, 32'h0000_0000);
      chan_set(7, 32'h0000_00A1, 32'h0000_0FFF, 32'h0000_0800);
      chan_set(4, 32'h0000_0111, 32'h0000_0800, 32'h0000_0900);
      rchk(8'h1C, 32'h0000_0000);
      wrr(8'h20, 32'h0002_0000);
      wrr(8'h24, 32'h0000_0010);
      chan_set(5, 32'h0000_0051, 32'h0000_04FF, 32'h0000_0000);
   endtask
   // Scaled alarm, high and low limits, memory and queue
   task automatic t_scan;
      wrr(8'h0C, 32'h0000_0001);
      rchk(8'h0C, 32'h0000_0001);
      scan(32'h0000_0001);
      chk(alarm, 4'b0111);
      chk(irq, 1'b1);
      wrr(8'h40, 32'h0000_0004);
      rchk(8'h44, 32'h0000_0810);
      rdr(8'h48);
      chk(v[2:0], 3'b110);
      rchk(8'h34, 32'h2100_0810);
      rchk(8'h34, 32'h2B00_0500);
      rchk(8'h34, 32'h3C00_0700);
      rchk(8'h34, 32'h0000_0000);
      wrr(8'h0C, 32'h0000_0000);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
   endtask
   // Preset keeps limits; trigger scan with slow front end
   task automatic t_trig;
      wrr(8'h00, 32'h0000_0010);
      rchk(8'h18, 32'h0000_04FF);
      wrr(8'h18, 32'h0000_0600);
      slow = 1'b1;
      scan(32'h0000_0005);
      slow = 1'b0;
      chk(alarm, 4'b0101);
      rchk(8'h04, 32'h0000_0108);
      wrr(8'h40, 32'h0000_0005);
      rdr(8'h48);
      chk(v[2:0], 3'b100);
   endtask
   task automatic t_reset;
      wrr(8'h00, 32'h0000_0008);
      rchk(8'h18, 32'h0000_0000);
      wrr(8'h10, 32'h0000_0004);
      rchk(8'h20, 32'h0001_0000);
   endtask
   task automatic t_mon;
      wrr(8'h38, 32'h8000_0007);
      repeat (30) @(posedge clk);
      rchk(8'h3C, 32'h0000_0700);
      wrr(8'h38, 32'h8000_0009);
      repeat (30) @(posedge clk);
      rchk(8'h3C, 32'h0000_0900);
   endtask
   task automatic end_sim;
      if (error_cnt == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Watchdog against a hang
   initial
   begin
      repeat (40000) @(posedge clk);
      error_cnt++;
      end_sim;
   end
   initial
   begin
      {nrst, wr, rd, trig, slow, addr, wdata} = '0;
      error_cnt = 0;
      checks = 0;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      t_regs;
      t_scan;
      t_trig;
      t_reset;
      t_mon;
      end_sim;
   end
endmodule
